//--- core/timer_mode_pkg.sv
// Package for the contactless countdown timer mode control.
// Assumes an 8-bit register port and a 100 MHz reference clock.
package timer_mode_pkg;

    // --------
    // Register offsets
    // --------
    localparam logic [15:0] TIMER_MODE_CONFIG_ADDR = 16'h631A;
    localparam logic [15:0] PRESCALER_LOWER_ADDR = 16'h631B;
    localparam logic [15:0] RELOAD_UPPER_ADDR = 16'h631C;
    localparam logic [15:0] RELOAD_LOWER_ADDR = 16'h631D;
    localparam logic [15:0] COUNT_UPPER_ADDR = 16'h631E;
    localparam logic [15:0] COUNT_LOWER_ADDR = 16'h631F;
    localparam logic [15:0] UNIT_CONTROL_ADDR = 16'h6320;
    localparam logic [15:0] TIMER_STATUS_ADDR = 16'h6321;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h6322;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h6323;

    // --------
    // Field positions
    // --------
    localparam int CTRL_START_NOW_BIT = 0;
    localparam int CTRL_STOP_NOW_BIT = 1;
    localparam int CTRL_INITIAL_FIELD_ON_BIT = 2;
    localparam int CTRL_MULTI_FRAME_BIT = 3;
    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int STATUS_GATE_OPEN_BIT = 1;
    localparam int IRQ_EXPIRED_BIT = 0;
    localparam int IRQ_AUTO_START_BIT = 1;
    localparam int IRQ_AUTO_STOP_BIT = 2;

    // --------
    // Reset values
    // --------
    localparam logic [7:0] TIMER_MODE_CONFIG_RST = 8'h00;
    localparam logic [7:0] PRESCALER_LOWER_RST = 8'h00;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [7:0] UNIT_CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;

    // --------
    // Timing
    // --------
    localparam int REF_CLK_HZ = 100000000;
    localparam int TIMER_BASE_HZ = 6780000;
    localparam int RATE_GCD_HZ = 10000;
    localparam logic [13:0] BASE_PHASE_STEP = 14'(TIMER_BASE_HZ / RATE_GCD_HZ);
    localparam logic [13:0] BASE_PHASE_MOD = 14'(REF_CLK_HZ / RATE_GCD_HZ);

    // --------
    // Encodings and carriers
    // --------
    typedef enum logic [1:0] {
        GATE_NONE = 2'h0,
        GATE_SECURE_LINK = 2'h1,
        GATE_AUX_TEST = 2'h2,
        GATE_RESERVED = 2'h3
    } gate_sel_e;

    typedef struct packed {
        logic auto_start_on_protocol;
        gate_sel_e gate_source_select;
        logic auto_reload;
        logic [3:0] prescaler_upper;
    } mode_cfg_s;

    typedef struct packed {
        logic tx_end;
        logic first_bit_rx;
        logic field_on;
    } proto_evt_s;

endpackage

//--- core/timer_tick_gen.sv
// Timer tick generator: 6.78 MHz base from the reference, then prescaler.
// Assumes the reference clock rate given in the package.
`timescale 1ns/100ps
module timer_tick_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic restart,
    input wire logic [11:0] prescaler,
    // Tick out
    output logic tick
);

    logic [13:0] phase_r;
    logic [13:0] phase_nxt;
    logic [11:0] div_r;
    logic [11:0] div_nxt;
    logic base_stb;
    logic [14:0] phase_sum;
    logic [11:0] div_last;

    // Fractional accumulator avoids a separate 6.78 MHz clock domain
    always_comb begin
        phase_sum = {1'b0, phase_r} + {1'b0, timer_mode_pkg::BASE_PHASE_STEP};
        base_stb = (phase_sum >= {1'b0, timer_mode_pkg::BASE_PHASE_MOD});
        phase_nxt = base_stb ? 14'(phase_sum - {1'b0, timer_mode_pkg::BASE_PHASE_MOD}) : phase_sum[13:0];
        // A prescaler of zero divides by one rather than stalling
        div_last = (prescaler == 12'h000) ? 12'h000 : 12'(prescaler - 12'h001);
        div_nxt = div_r;
        tick = 1'b0;
        if (restart) begin
            div_nxt = 12'h000;
        end else if (base_stb) begin
            if (div_r >= div_last) begin // see [RQ9]
                div_nxt = 12'h000;
                tick = 1'b1;
            end else begin
                div_nxt = 12'(div_r + 12'h001);
            end
        end
    end

    // Registers only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= 14'h0000;
            div_r <= 12'h000;
        end else begin
            phase_r <= phase_nxt;
            div_r <= div_nxt;
        end
    end

endmodule

//--- core/countdown_core.sv
// Sixteen-bit countdown with optional reload on reaching zero.
// Assumes tick_en is already gated by run state and gate input.
`timescale 1ns/100ps
module countdown_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic tick_en,
    input wire logic auto_reload,
    input wire logic [15:0] reload_value,
    // State
    output logic [15:0] count,
    output logic zero_hit
);

    logic [15:0] count_r;
    logic [15:0] count_nxt;

    // Load wins over a tick in the same cycle
    always_comb begin
        count_nxt = count_r;
        zero_hit = 1'b0;
        if (load) begin
            count_nxt = reload_value;
        end else if (tick_en) begin
            if (count_r == 16'h0000) begin
                zero_hit = 1'b1;
                count_nxt = auto_reload ? reload_value : 16'h0000; // see [RQ10]
            end else begin
                count_nxt = 16'(count_r - 16'h0001);
            end
        end
    end

    // Registers only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_r <= timer_mode_pkg::RELOAD_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule

//--- core/contactless_timer_mode_ctrl.sv
// Mode control for the contactless countdown timer: mode register,
// protocol-driven start and stop, gating, tick generation and interrupt.
// Assumes protocol event inputs are one-cycle pulses synchronous to ref_clk,
// field_on is a level, and the register master never waits.
//
// Function
// [RQ1] Auto-start set: end of transmission starts timer in every mode and rate.
// [RQ2] Auto-start and initial-field-on set: external field switching on starts timer.
// [RQ3] Auto-start set, multi-frame off: first received data bit stops timer at once.
// [RQ4] Auto-start set, multi-frame on: reception never stops; only stop-now does (expiry without auto-reload also stops it here).
// [RQ5] Auto-start clear: protocol events neither start nor stop the timer.
// [RQ6] Gate field 00 means no gating; 01 gates counting by secure link input.
// [RQ7] In gated mode active flag reads 1 whenever enabled, regardless of gate level.
// [RQ8] Mode register is 8-bit read-write, fields at 7, 6:5, 4, 3:0, reset zero.
// [RQ9] Upper four prescaler bits join lower byte; tick is 6.78 MHz over prescaler.
// [RQ10] Auto-reload restarts countdown at zero; otherwise stop and set expired flag.
// [RQ11] Gate code 10 gates by auxiliary test input; code 11 is reserved.
`timescale 1ns/100ps
module contactless_timer_mode_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Transceiver events
    input wire timer_mode_pkg::proto_evt_s proto_evt,
    // Gate sources
    input wire logic secure_link_input,
    input wire logic auxiliary_test_input,
    // Status and interrupt
    output logic timer_active_flag,
    output logic countdown_expired_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } run_state_e;

    // ------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------
    timer_mode_pkg::mode_cfg_s mode_r;
    timer_mode_pkg::mode_cfg_s mode_nxt;
    logic [7:0] presc_lower_r;
    logic [7:0] presc_lower_nxt;
    logic [15:0] reload_r;
    logic [15:0] reload_nxt;
    logic initial_field_on_r;
    logic initial_field_on_nxt;
    logic multi_frame_receive_r;
    logic multi_frame_receive_nxt;
    logic [7:0] irq_mask_r;
    logic [7:0] irq_mask_nxt;
    logic [7:0] irq_stat_r;
    logic [7:0] irq_stat_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Software pulses decoded from the control register
    logic ctrl_wr;
    logic start_timer_now;
    logic stop_timer_now;

    // Protocol and run logic
    run_state_e state_r;
    run_state_e state_nxt;
    logic field_on_prev_r;
    logic field_on_prev_nxt;
    logic field_rise;
    logic auto_start_evt;
    logic auto_stop_evt;
    logic start_evt;
    logic stop_evt;
    logic gate_open;
    logic tick;
    logic tick_en;
    logic zero_hit;
    logic expire_stop;
    logic [15:0] count;
    logic [11:0] prescaler;

    // ------------------------------------------------------------
    // Protocol start and stop
    // ------------------------------------------------------------
    // Field detection reacts only to the off-to-on transition
    always_comb begin
        field_on_prev_nxt = proto_evt.field_on;
        field_rise = proto_evt.field_on & ~field_on_prev_r;
        auto_start_evt = 1'b0;
        auto_stop_evt = 1'b0;
        if (mode_r.auto_start_on_protocol) begin // see [RQ5]
            if (proto_evt.tx_end) begin
                auto_start_evt = 1'b1; // see [RQ1]
            end
            if (initial_field_on_r && field_rise) begin
                auto_start_evt = 1'b1; // see [RQ2]
            end
            // Multi-frame reception leaves only the software stop and, without auto-reload, expiry
            if (proto_evt.first_bit_rx && !multi_frame_receive_r) begin // see [RQ4]
                auto_stop_evt = 1'b1; // see [RQ3]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            field_on_prev_r <= 1'b0;
        end else begin
            field_on_prev_r <= field_on_prev_nxt;
        end
    end

    // ------------------------------------------------------------
    // Gating
    // ------------------------------------------------------------
    // Reserved code holds the count rather than guessing a source
    always_comb begin
        case (mode_r.gate_source_select)
            timer_mode_pkg::GATE_NONE: gate_open = 1'b1; // see [RQ6]
            timer_mode_pkg::GATE_SECURE_LINK: gate_open = secure_link_input; // see [RQ6]
            timer_mode_pkg::GATE_AUX_TEST: gate_open = auxiliary_test_input; // see [RQ11]
            default: gate_open = 1'b0; // see [RQ11]
        endcase
    end

    // ------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------
    // A stop in the same cycle as a start wins, so a stray start cannot
    // override an explicit halt from software or the receiver.
    always_comb begin
        start_evt = auto_start_evt | start_timer_now;
        expire_stop = zero_hit & ~mode_r.auto_reload; // see [RQ10]
        stop_evt = auto_stop_evt | stop_timer_now | expire_stop; // see [RQ4]
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_evt && !stop_evt) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_evt) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Active flag follows run state only, never the gate level
    assign timer_active_flag = (state_r == ST_RUN); // see [RQ7]

    // ------------------------------------------------------------
    // Tick and countdown
    // ------------------------------------------------------------
    assign prescaler = {mode_r.prescaler_upper, presc_lower_r}; // see [RQ9]
    assign tick_en = tick & gate_open & timer_active_flag;

    timer_tick_gen u_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .restart(start_evt),
        .prescaler(prescaler),
        .tick(tick)
    );

    // Every start reloads, so a restart mid-count begins afresh
    countdown_core u_count (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(start_evt & ~stop_evt),
        .tick_en(tick_en),
        .auto_reload(mode_r.auto_reload),
        .reload_value(reload_r),
        .count(count),
        .zero_hit(zero_hit)
    );

    // ------------------------------------------------------------
    // Register writes and interrupt status
    // ------------------------------------------------------------
    assign ctrl_wr = reg_write && (reg_addr == timer_mode_pkg::UNIT_CONTROL_ADDR);
    assign start_timer_now = ctrl_wr & reg_wdata[timer_mode_pkg::CTRL_START_NOW_BIT];
    assign stop_timer_now = ctrl_wr & reg_wdata[timer_mode_pkg::CTRL_STOP_NOW_BIT];

    // Status bits are sticky; a new event beats the clear-on-read
    always_comb begin
        mode_nxt = mode_r;
        presc_lower_nxt = presc_lower_r;
        reload_nxt = reload_r;
        initial_field_on_nxt = initial_field_on_r;
        multi_frame_receive_nxt = multi_frame_receive_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        if (reg_write) begin
            case (reg_addr)
                timer_mode_pkg::TIMER_MODE_CONFIG_ADDR: mode_nxt = reg_wdata; // see [RQ8]
                timer_mode_pkg::PRESCALER_LOWER_ADDR: presc_lower_nxt = reg_wdata;
                timer_mode_pkg::RELOAD_UPPER_ADDR: reload_nxt[15:8] = reg_wdata;
                timer_mode_pkg::RELOAD_LOWER_ADDR: reload_nxt[7:0] = reg_wdata;
                timer_mode_pkg::UNIT_CONTROL_ADDR: begin
                    initial_field_on_nxt = reg_wdata[timer_mode_pkg::CTRL_INITIAL_FIELD_ON_BIT];
                    multi_frame_receive_nxt = reg_wdata[timer_mode_pkg::CTRL_MULTI_FRAME_BIT];
                end
                timer_mode_pkg::IRQ_MASK_ADDR: irq_mask_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_read && (reg_addr == timer_mode_pkg::IRQ_STATUS_ADDR)) begin
            irq_stat_nxt = 8'h00;
        end
        if (zero_hit) begin
            irq_stat_nxt[timer_mode_pkg::IRQ_EXPIRED_BIT] = 1'b1; // see [RQ10]
        end
        if (auto_start_evt) begin
            irq_stat_nxt[timer_mode_pkg::IRQ_AUTO_START_BIT] = 1'b1;
        end
        if (auto_stop_evt) begin
            irq_stat_nxt[timer_mode_pkg::IRQ_AUTO_STOP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_r <= timer_mode_pkg::TIMER_MODE_CONFIG_RST; // see [RQ8]
            presc_lower_r <= timer_mode_pkg::PRESCALER_LOWER_RST;
            reload_r <= timer_mode_pkg::RELOAD_RST;
            initial_field_on_r <= 1'b0;
            multi_frame_receive_r <= 1'b0;
            irq_mask_r <= timer_mode_pkg::IRQ_MASK_RST;
            irq_stat_r <= 8'h00;
        end else begin
            mode_r <= mode_nxt;
            presc_lower_r <= presc_lower_nxt;
            reload_r <= reload_nxt;
            initial_field_on_r <= initial_field_on_nxt;
            multi_frame_receive_r <= multi_frame_receive_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign countdown_expired_flag = irq_stat_r[timer_mode_pkg::IRQ_EXPIRED_BIT];
    assign irq = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Read data stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                timer_mode_pkg::TIMER_MODE_CONFIG_ADDR: rdata_nxt = mode_r; // see [RQ8]
                timer_mode_pkg::PRESCALER_LOWER_ADDR: rdata_nxt = presc_lower_r;
                timer_mode_pkg::RELOAD_UPPER_ADDR: rdata_nxt = reload_r[15:8];
                timer_mode_pkg::RELOAD_LOWER_ADDR: rdata_nxt = reload_r[7:0];
                timer_mode_pkg::COUNT_UPPER_ADDR: rdata_nxt = count[15:8];
                timer_mode_pkg::COUNT_LOWER_ADDR: rdata_nxt = count[7:0];
                timer_mode_pkg::UNIT_CONTROL_ADDR: begin
                    rdata_nxt[timer_mode_pkg::CTRL_INITIAL_FIELD_ON_BIT] = initial_field_on_r;
                    rdata_nxt[timer_mode_pkg::CTRL_MULTI_FRAME_BIT] = multi_frame_receive_r;
                end
                timer_mode_pkg::TIMER_STATUS_ADDR: begin
                    rdata_nxt[timer_mode_pkg::STATUS_ACTIVE_BIT] = timer_active_flag; // see [RQ7]
                    rdata_nxt[timer_mode_pkg::STATUS_GATE_OPEN_BIT] = gate_open;
                end
                timer_mode_pkg::IRQ_STATUS_ADDR: rdata_nxt = irq_stat_r;
                timer_mode_pkg::IRQ_MASK_ADDR: rdata_nxt = irq_mask_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

//--- verification/timer_mode_ctrl_sva.sv
// Port checker for the timer mode control.
// Assumes one-cycle register strobes and one ref_clk domain.
`timescale 1ns/100ps
module timer_mode_ctrl_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Events and gates
    input wire timer_mode_pkg::proto_evt_s proto_evt,
    input wire logic secure_link_input,
    input wire logic auxiliary_test_input,
    // Status
    input wire logic timer_active_flag,
    input wire logic countdown_expired_flag,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // --------
    // Shadows of mode and control registers
    // --------
    // Only written bytes are tracked; control bits 2 and 3 are the levels
    logic [7:0] mode_r;
    logic [7:0] ctl_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_r <= 8'h00;
            ctl_r <= 8'h00;
        end else if (reg_write && reg_addr == timer_mode_pkg::TIMER_MODE_CONFIG_ADDR) begin
            mode_r <= reg_wdata;
        end else if (reg_write && reg_addr == timer_mode_pkg::UNIT_CONTROL_ADDR) begin
            ctl_r <= reg_wdata;
        end
    end

    // --------
    // Properties
    // --------
    property p_tx_start;
        mode_r[7] && proto_evt.tx_end && !timer_active_flag && !reg_write && !proto_evt.first_bit_rx
            |=> timer_active_flag;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("end of transmission did not start");
    property p_field_start;
        mode_r[7] && ctl_r[2] && $rose(proto_evt.field_on) && !timer_active_flag && !reg_write
            && !proto_evt.first_bit_rx |=> timer_active_flag;
    endproperty
    a_field_start: assert property (p_field_start) else $error("field on did not start");
    property p_rx_stop;
        mode_r[7] && !ctl_r[3] && proto_evt.first_bit_rx |=> !timer_active_flag;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("first bit did not stop");
    property p_rx_hold;
        mode_r[7] && ctl_r[3] && mode_r[4] && timer_active_flag && !reg_write |=> timer_active_flag;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("timer stopped in multi frame");
    property p_no_auto;
        !mode_r[7] && !timer_active_flag && !reg_write |=> !timer_active_flag;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("protocol started timer");
    property p_gate_hold;
        mode_r[6:5] == 2'h1 && !secure_link_input && timer_active_flag && !reg_write
            && !proto_evt.first_bit_rx |=> timer_active_flag;
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("active dropped while gated");
    property p_mode_rd;
        reg_read && reg_addr == timer_mode_pkg::TIMER_MODE_CONFIG_ADDR |=> reg_rdata == mode_r;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read mismatch");
    property p_rd_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_expire_stop;
        $rose(countdown_expired_flag) && !mode_r[4] && !reg_write |-> ##[0:1] !timer_active_flag;
    endproperty
    a_expire_stop: assert property (p_expire_stop) else $error("timer ran on past zero");
endmodule

bind contactless_timer_mode_ctrl timer_mode_ctrl_sva u_timer_mode_ctrl_sva (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .proto_evt(proto_evt), .secure_link_input(secure_link_input),
    .auxiliary_test_input(auxiliary_test_input), .timer_active_flag(timer_active_flag),
    .countdown_expired_flag(countdown_expired_flag), .irq(irq)
);

//--- verification/xcvr_model.sv
// Transceiver framing events and gate sources seen by the timer.
// Assumes the bench calls one task at a time, between clock edges.
`timescale 1ns/100ps
module xcvr_model (
    // Clock
    input wire logic ref_clk,
    // Events and gates
    output timer_mode_pkg::proto_evt_s proto_evt,
    output logic secure_link_input,
    output logic auxiliary_test_input
);
    // Idle: no events, no field, both gates closed
    initial begin
        proto_evt = '0;
        secure_link_input = 1'b0;
        auxiliary_test_input = 1'b0;
    end
    // One-cycle pulse; index 2 is end of transmission, 1 first data bit
    task automatic pulse(input int idx);
        @(posedge ref_clk);
        proto_evt[idx] <= 1'b1;
        @(posedge ref_clk);
        proto_evt[idx] <= 1'b0;
    endtask
    // Field presence is a level; its rising edge is the event
    task automatic field(input logic on);
        @(posedge ref_clk);
        proto_evt.field_on <= on;
    endtask
    task automatic gates(input logic s, input logic a);
        @(posedge ref_clk);
        secure_link_input <= s;
        auxiliary_test_input <= a;
    endtask
endmodule

//--- verification/contactless_timer_mode_ctrl_tb.sv
// Self-checking bench for the timer mode control.
// Assumes the register map and irq layout of the package.
`timescale 1ns/100ps
module contactless_timer_mode_ctrl_tb;
    localparam logic [15:0] MODE = timer_mode_pkg::TIMER_MODE_CONFIG_ADDR;
    localparam logic [15:0] CTL = timer_mode_pkg::UNIT_CONTROL_ADDR;
    localparam logic [15:0] CNT_LO = timer_mode_pkg::COUNT_LOWER_ADDR;
    localparam logic [15:0] ISTAT = timer_mode_pkg::IRQ_STATUS_ADDR;
    logic ref_clk, reset, reg_write, reg_read;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, d1;
    timer_mode_pkg::proto_evt_s proto_evt;
    logic secure_link_input, auxiliary_test_input, timer_active_flag, countdown_expired_flag, irq;
    int num_errors = 0;
    int checked = 0;
    int n;

    contactless_timer_mode_ctrl u_contactless_timer_mode_ctrl (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .proto_evt(proto_evt), .secure_link_input(secure_link_input),
        .auxiliary_test_input(auxiliary_test_input), .timer_active_flag(timer_active_flag),
        .countdown_expired_flag(countdown_expired_flag), .irq(irq));
    xcvr_model u_xcvr_model (.ref_clk(ref_clk), .proto_evt(proto_evt),
        .secure_link_input(secure_link_input), .auxiliary_test_input(auxiliary_test_input));

    // --------
    // Clock, compare and bus tasks
    // --------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic flag(input logic e);
        #1 chk({7'h00, timer_active_flag}, {7'h00, e});
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        rd(MODE); chk(d, timer_mode_pkg::TIMER_MODE_CONFIG_RST);
        wr(MODE, 8'hA5); rd(MODE); chk(d, 8'hA5);
        wr(MODE, 8'h5A); rd(MODE); chk(d, 8'h5A);
        wr(16'h6300, 8'hFF); rd(16'h6300); chk(d, 8'h00);
    endtask
    // Slow prescaler and full reload keep expiry out of the protocol cases
    task automatic t_auto;
        wr(16'h631B, 8'hFF);
        wr(16'h631C, 8'hFF);
        wr(16'h631D, 8'hFF);
        wr(16'h6323, 8'h02);
        wr(MODE, 8'h9F);
        u_xcvr_model.pulse(2); flag(1'b1);
        chk({7'h00, irq}, 8'h01);
        u_xcvr_model.pulse(1); flag(1'b0);
        rd(ISTAT); chk(d, 8'h06);
        chk({7'h00, irq}, 8'h00);
        wr(CTL, 8'h08);
        u_xcvr_model.pulse(2); flag(1'b1);
        u_xcvr_model.pulse(1); flag(1'b1);
        wr(CTL, 8'h0A); flag(1'b0);
        wr(CTL, 8'h04);
        u_xcvr_model.field(1'b1);
        @(posedge ref_clk); flag(1'b1);
        wr(CTL, 8'h02); u_xcvr_model.field(1'b0);
        wr(MODE, 8'h0F);
        u_xcvr_model.pulse(2); flag(1'b0);
        u_xcvr_model.field(1'b1);
        repeat (2) @(posedge ref_clk);
        flag(1'b0);
        u_xcvr_model.field(1'b0);
        rd(ISTAT); chk(d, 8'h02);
    endtask
    // Code 1 gates by the secure link, code 2 by the test input
    task automatic t_gate;
        wr(16'h631B, 8'h01);
        for (int g = 1; g < 3; g++) begin
            wr(MODE, 8'(g << 5));
            u_xcvr_model.gates(g == 2, g == 1);
            wr(CTL, 8'h01);
            rd(16'h6321); chk(d & 8'h01, 8'h01);
            rd(CNT_LO); d1 = d;
            repeat (60) @(posedge ref_clk);
            rd(CNT_LO); chk(d, d1);
            u_xcvr_model.gates(g == 1, g == 2);
            repeat (60) @(posedge ref_clk);
            rd(CNT_LO); chk({7'h00, d == d1}, 8'h00);
            wr(CTL, 8'h02);
        end
    endtask
    // Prescaler 1 gives a tick about every 14.75 cycles; reload 2 needs 3 ticks
    task automatic t_expire;
        wr(16'h631C, 8'h00);
        wr(16'h631D, 8'h02);
        wr(16'h6323, 8'h01);
        for (int r = 0; r < 2; r++) begin
            wr(MODE, 8'(r << 4));
            wr(CTL, 8'h01);
            n = 0;
            while (countdown_expired_flag !== 1'b1 && n < 200) begin
                @(posedge ref_clk);
                #1 n++;
            end
            chk({7'h00, n >= 29 && n <= 45}, 8'h01);
            chk({7'h00, irq}, 8'h01);
            repeat (2) @(posedge ref_clk);
            flag(r == 1);
            rd(ISTAT); chk(d, 8'h01);
            chk({7'h00, irq}, 8'h00);
            wr(CTL, 8'h02);
        end
    endtask

    // --------
    // Main sequence and watchdog
    // --------
    initial begin
        reset = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs;
        t_auto;
        t_gate;
        t_expire;
        close_out;
    end
    // Whole run is several hundred cycles; this is far beyond it
    initial begin
        #200000;
        num_errors++;
        close_out;
    end
endmodule
